// [rtl/watchdog_and_reset_cause_pkg.sv]
// constants, carriers and state layout for the watchdog and reset-cause block
// assumes one 250 MHz system clock and byte-wide special-register accesses
package watchdog_and_reset_cause_pkg;

  // ************************************************************
  // register map and reset values
  // ************************************************************
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'he3; // watchdog control
  localparam logic [7:0] RESET_CAUSE_ADDR      = 8'hef; // reset cause
  localparam logic [7:0] WATCHDOG_CONTROL_RST  = 8'h17; // active, interval 7
  localparam logic [2:0] INTERVAL_RST          = 3'h7;  // longest interval

  // ************************************************************
  // watchdog keywords and field positions
  // ************************************************************
  localparam logic [7:0] KEY_RESTART   = 8'ha5; // enable and restart
  localparam logic [7:0] KEY_DISABLE_1 = 8'hde; // first disable keyword
  localparam logic [7:0] KEY_DISABLE_2 = 8'had; // second disable keyword
  localparam logic [7:0] KEY_LOCK      = 8'hff; // lock out disable
  localparam int         INTERVAL_GATE_BIT = 7; // must be zero to set interval
  localparam int         ACTIVE_BIT        = 4; // watchdog_active_bit
  localparam logic [2:0] DISABLE_WINDOW    = 3'h4; // cycles allowed between keys
  localparam logic [4:0] INTERVAL_BASE_EXP = 5'h6; // 4^3 as a power of two

  // ************************************************************
  // reset_cause bit positions
  // ************************************************************
  localparam int FLASH_ERROR_BIT = 6; // flash_error_flag
  localparam int COMPARATOR_BIT  = 5; // comparator_reset_enable_flag
  localparam int SOFTWARE_BIT    = 4; // software_reset_force_flag
  localparam int WATCHDOG_BIT    = 3; // watchdog_reset_flag
  localparam int MISSING_CLK_BIT = 2; // missing_clock_enable_flag
  localparam int POWER_BIT       = 1; // power_monitor_reset_flag
  localparam int PIN_BIT         = 0; // pin_reset_flag

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS          = 4;      // system clock period
  localparam int GAP_TIMEOUT_NS         = 100000; // missing clock limit, 100 us
  localparam int GAP_TIMEOUT_CYCLES     = GAP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [3:0] RESET_HOLD_CYCLES = 4'h8; // internal reset stretch

  // ************************************************************
  // carriers and state
  // ************************************************************
  typedef struct packed {
    logic [7:0] addr;  // special register address
    logic       wr;    // write strobe
    logic       rd;    // read strobe
    logic [7:0] wdata; // write data
  } sfr_req_t;

  typedef struct packed {
    logic flash_error;    // illegal flash access pulse
    logic comparator_n;   // comparator output, low requests reset
    logic supply_low;     // supply monitor below threshold
    logic reset_pin_n;    // external reset pin level
    logic monitored_clk;  // sampled clock watched for stalls
  } reset_sources_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01, // normal operation
    ST_HOLD = 2'b10  // internal system reset asserted
  } sys_state_t;

endpackage

// [rtl/watchdog_and_reset_cause.sv]
// watchdog timer with keyword control plus the reset-cause register
// assumes byte register accesses synchronous to clock_i and synchronous sources
// Contract
// - flash error flag bit 6, read only
// - bit 5 enables comparator reset, flags it
// - writing bit 4 forces reset, flags software
// - bit 3 flags watchdog reset, read only
// - bit 2 enables missing clock reset, flags
// - bit 1 enables supply reset, flags power
// - bit 0 flags pin reset, read only
// - watchdog overflow resets and sets its flag
// - watchdog reset never drives reset pin
// - 21-bit counter on system clock
// - 0xa5 enables watchdog and clears counter
// - 0xde then 0xad within 4 cycles disables
// - 0xff locks disable, no restart, until reset
// - interval is 4 to (3 plus field) cycles
// - interval written only when bit 7 clear
// - control read returns interval in low bits
// - after reset watchdog runs, interval all ones
// - missing clock beyond 100 us resets
`timescale 1ns/100ps

module watchdog_and_reset_cause
  import watchdog_and_reset_cause_pkg::*;
#(
  parameter int WDT_WIDTH   = 21,                // watchdog counter width
  parameter int GAP_CYCLES  = GAP_TIMEOUT_CYCLES, // missing clock limit in cycles
  parameter int GAP_WIDTH   = 16                 // missing clock counter width
) (
  input  wire logic                                       clock_i,   // system clock
  input  wire logic                                       rst_i,     // power-on reset
  input  wire logic                                       ce_i,      // clock enable
  input  wire watchdog_and_reset_cause_pkg::sfr_req_t     sfr_i,     // register access
  input  wire watchdog_and_reset_cause_pkg::reset_sources_t src_i,   // reset sources
  output logic [7:0]                                      rdata_o,   // read data
  output logic                                            sys_reset_o, // system reset
  output logic                                            wd_active_o  // watchdog running
);
  import watchdog_and_reset_cause_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    sys_state_t           st;          // run or holding reset
    logic [3:0]           hold_cnt;    // reset stretch counter
    logic [WDT_WIDTH-1:0] wd_cnt;      // watchdog counter
    logic                 wd_en;       // watchdog enabled
    logic                 wd_lock;     // disable locked out
    logic [2:0]           interval;    // timeout interval field
    logic [2:0]           dis_win;     // cycles left for second key
    logic [6:0]           flags;       // reset cause flags
    logic                 comp_en;     // comparator reset enable
    logic                 gap_en;      // missing clock enable
    logic                 supply_en;   // supply monitor enable
    logic                 mclk_last;   // last monitored clock sample
    logic [GAP_WIDTH-1:0] gap_cnt;     // cycles without a clock edge
    logic [7:0]           rdata;       // read data register
  } state_t;

  state_t state_reg;  // registered state
  state_t state_next; // next state

  // ************************************************************
  // decode
  // ************************************************************
  logic                 wr_wdc;     // write to watchdog control
  logic                 wr_rc;      // write to reset cause
  logic                 rd_wdc;     // read of watchdog control
  logic                 running;    // not holding reset
  logic [4:0]           exp_sh;     // interval as power of two
  logic [WDT_WIDTH-1:0] wd_limit;   // timeout count
  logic                 wd_ovf;     // watchdog overflow this cycle
  logic                 gap_trip;   // missing clock timeout
  logic [6:0]           cause;      // cause of a new reset
  logic [7:0]           wdc_read;   // watchdog control read value

  assign running  = (state_reg.st == ST_RUN);
  assign wr_wdc   = sfr_i.wr && (sfr_i.addr == WATCHDOG_CONTROL_ADDR) && running;
  assign wr_rc    = sfr_i.wr && (sfr_i.addr == RESET_CAUSE_ADDR) && running;
  assign rd_wdc   = sfr_i.rd && (sfr_i.addr == WATCHDOG_CONTROL_ADDR);
  // limit is 4^(3+field) system clocks
  assign exp_sh   = INTERVAL_BASE_EXP + {1'b0, state_reg.interval, 1'b0};
  assign wd_limit = WDT_WIDTH'(1) << exp_sh;
  // overflow when the count reaches or passes one below the limit with no restart
  // a shorter interval written late still trips instead of wrapping
  assign wd_ovf   = state_reg.wd_en && (state_reg.wd_cnt >= wd_limit - WDT_WIDTH'(1));
  // clock held at one level beyond the limit
  assign gap_trip = state_reg.gap_en
                    && (state_reg.gap_cnt >= GAP_WIDTH'(GAP_CYCLES - 1));
  assign wdc_read = {3'h0, state_reg.wd_en, 1'b0, state_reg.interval};

  // ************************************************************
  // cause of a fresh reset, one flag at a time by priority
  // ************************************************************
  always_comb begin
    cause = 7'h00;
    if (!src_i.reset_pin_n) begin
      cause[PIN_BIT] = 1'b1;
    end else if (state_reg.supply_en && src_i.supply_low) begin
      cause[POWER_BIT] = 1'b1;
    end else if (gap_trip) begin
      cause[MISSING_CLK_BIT] = 1'b1;
    end else if (wd_ovf) begin
      cause[WATCHDOG_BIT] = 1'b1;
    end else if (wr_rc && sfr_i.wdata[SOFTWARE_BIT]) begin
      cause[SOFTWARE_BIT] = 1'b1;
    end else if (state_reg.comp_en && !src_i.comparator_n) begin
      cause[COMPARATOR_BIT] = 1'b1;
    end else if (src_i.flash_error) begin
      cause[FLASH_ERROR_BIT] = 1'b1;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    // registered read data, bit 7 of reset cause reads zero
    if (sfr_i.rd) begin
      if (rd_wdc) begin
        state_next.rdata = wdc_read;
      end else if (sfr_i.addr == RESET_CAUSE_ADDR) begin
        state_next.rdata = {1'b0, state_reg.flags};
      end else begin
        state_next.rdata = 8'h00; // unmapped address
      end
    end
    // missing clock detector watches level changes
    state_next.mclk_last = src_i.monitored_clk;
    if (src_i.monitored_clk != state_reg.mclk_last || !state_reg.gap_en) begin
      state_next.gap_cnt = '0;
    end else if (!gap_trip) begin
      state_next.gap_cnt = state_reg.gap_cnt + GAP_WIDTH'(1);
    end
    case (state_reg.st)
      ST_RUN: begin
        // watchdog counts every enabled system clock
        if (state_reg.wd_en) begin
          state_next.wd_cnt = state_reg.wd_cnt + WDT_WIDTH'(1);
        end
        // disable window ages one per cycle
        if (state_reg.dis_win != 3'h0) begin
          state_next.dis_win = state_reg.dis_win - 3'h1;
        end
        if (wr_wdc) begin
          // interval only takes writes with bit 7 clear
          if (!sfr_i.wdata[INTERVAL_GATE_BIT]) begin
            state_next.interval = sfr_i.wdata[2:0];
          end
          state_next.dis_win = 3'h0;
          case (sfr_i.wdata)
            KEY_RESTART: begin
              state_next.wd_en  = 1'b1;
              state_next.wd_cnt = '0;
            end
            KEY_DISABLE_1: begin
              // first keyword opens the window unless locked
              if (!state_reg.wd_lock) begin
                state_next.dis_win = DISABLE_WINDOW;
              end
            end
            KEY_DISABLE_2: begin
              // second keyword only counts inside the window
              if (state_reg.dis_win != 3'h0 && !state_reg.wd_lock) begin
                state_next.wd_en = 1'b0;
              end
            end
            KEY_LOCK: begin
              state_next.wd_lock = 1'b1;
            end
            default: begin
            end
          endcase
        end
        // enables take the whole written value
        if (wr_rc) begin
          state_next.comp_en   = sfr_i.wdata[COMPARATOR_BIT];
          state_next.gap_en    = sfr_i.wdata[MISSING_CLK_BIT];
          state_next.supply_en = sfr_i.wdata[POWER_BIT];
        end
        // any source enters internal reset, pin stays untouched
        if (cause != 7'h00) begin
          state_next.st       = ST_HOLD;
          state_next.hold_cnt = RESET_HOLD_CYCLES;
          state_next.flags    = cause;
        end
      end
      ST_HOLD: begin
        // watchdog and enables return to reset values
        state_next.wd_en     = 1'b1;
        state_next.wd_cnt    = '0;
        state_next.interval  = INTERVAL_RST;
        state_next.wd_lock   = 1'b0;
        state_next.dis_win   = 3'h0;
        state_next.comp_en   = 1'b0;
        state_next.gap_en    = 1'b0;
        state_next.supply_en = 1'b0;
        if (state_reg.hold_cnt != 4'h0) begin
          state_next.hold_cnt = state_reg.hold_cnt - 4'h1;
        end else if (src_i.reset_pin_n) begin
          state_next.st = ST_RUN; // exit waits for the pin to be released
        end
      end
      default: begin
        state_next.st = ST_HOLD;
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg.st        <= ST_HOLD;
      state_reg.hold_cnt  <= RESET_HOLD_CYCLES;
      state_reg.wd_cnt    <= '0;
      state_reg.wd_en     <= WATCHDOG_CONTROL_RST[ACTIVE_BIT];
      state_reg.wd_lock   <= 1'b0;
      state_reg.interval  <= WATCHDOG_CONTROL_RST[2:0];
      state_reg.dis_win   <= 3'h0;
      state_reg.flags     <= 7'h02;
      state_reg.comp_en   <= 1'b0;
      state_reg.gap_en    <= 1'b0;
      state_reg.supply_en <= 1'b0;
      state_reg.mclk_last <= 1'b0;
      state_reg.gap_cnt   <= '0;
      state_reg.rdata     <= 8'h00;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rdata_o     = state_reg.rdata;
  assign sys_reset_o = (state_reg.st == ST_HOLD); // internal only
  assign wd_active_o = state_reg.wd_en;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_restart;
    ce_i && wr_wdc && sfr_i.wdata == KEY_RESTART && cause == 7'h00
      |=> state_reg.wd_en && state_reg.wd_cnt == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart keyword ignored");

  property p_lock_keeps;
    ce_i && wr_wdc && sfr_i.wdata == KEY_LOCK && cause == 7'h00
      |=> state_reg.wd_en == $past(state_reg.wd_en) && state_reg.wd_lock;
  endproperty
  a_lock_keeps: assert property (p_lock_keeps) else $error("lock changed enable");

  property p_disable;
    ce_i && wr_wdc && sfr_i.wdata == KEY_DISABLE_2 && state_reg.dis_win != 3'h0
      && !state_reg.wd_lock && cause == 7'h00 |=> !state_reg.wd_en;
  endproperty
  a_disable: assert property (p_disable) else $error("disable sequence failed");

  property p_locked_on;
    ce_i && running && state_reg.wd_lock && state_reg.wd_en |=> state_reg.wd_en;
  endproperty
  a_locked_on: assert property (p_locked_on) else $error("locked watchdog stopped");

  property p_interval;
    ce_i && wr_wdc && !sfr_i.wdata[INTERVAL_GATE_BIT] && cause == 7'h00
      |=> state_reg.interval == $past(sfr_i.wdata[2:0]);
  endproperty
  a_interval: assert property (p_interval) else $error("interval not written");

  property p_interval_gate;
    ce_i && running && wr_wdc && sfr_i.wdata[INTERVAL_GATE_BIT] && cause == 7'h00
      |=> $stable(state_reg.interval);
  endproperty
  a_interval_gate: assert property (p_interval_gate) else $error("gated interval moved");

  property p_overflow;
    ce_i && running && wd_ovf && src_i.reset_pin_n && !gap_trip
      && !(state_reg.supply_en && src_i.supply_low)
      |=> sys_reset_o && state_reg.flags[WATCHDOG_BIT];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow gave no reset");

  property p_software;
    ce_i && wr_rc && sfr_i.wdata[SOFTWARE_BIT] && src_i.reset_pin_n && !gap_trip
      && !wd_ovf && !(state_reg.supply_en && src_i.supply_low)
      |=> sys_reset_o && state_reg.flags == 7'h10;
  endproperty
  a_software: assert property (p_software) else $error("software reset missing");

  property p_after_reset;
    $fell(sys_reset_o) |-> state_reg.wd_en && state_reg.interval == INTERVAL_RST;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("watchdog not restored");

  property p_read_wdc;
    ce_i && rd_wdc |=> rdata_o[2:0] == $past(state_reg.interval);
  endproperty
  a_read_wdc: assert property (p_read_wdc) else $error("interval read wrong");

  property p_pin;
    ce_i && running && !src_i.reset_pin_n |=> sys_reset_o && state_reg.flags[PIN_BIT];
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset not flagged");

  property p_flags_ro;
    ce_i && wr_rc && cause == 7'h00 |=> $stable(state_reg.flags);
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("flags written by software");

  // frozen clock enable holds every state bit
  property p_freeze;
    !ce_i |=> $stable(state_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // second keyword outside the window leaves the watchdog on
  property p_late_disable;
    ce_i && wr_wdc && sfr_i.wdata == KEY_DISABLE_2 && state_reg.dis_win == 3'h0
      && state_reg.wd_en |=> state_reg.wd_en;
  endproperty
  a_late_disable: assert property (p_late_disable) else $error("late key accepted");

  // any other control write closes the disable window
  property p_abandon;
    ce_i && wr_wdc && sfr_i.wdata != KEY_DISABLE_1 |=> state_reg.dis_win == 3'h0;
  endproperty
  a_abandon: assert property (p_abandon) else $error("disable window left open");

  c_restart:  cover property (ce_i && wr_wdc && sfr_i.wdata == KEY_RESTART);
  c_disable:  cover property (ce_i && running && $fell(state_reg.wd_en));
  c_overflow: cover property (ce_i && running && wd_ovf);
  c_software: cover property (ce_i && wr_rc && sfr_i.wdata[SOFTWARE_BIT]);
  c_pin:      cover property (ce_i && running && !src_i.reset_pin_n);

endmodule // watchdog_and_reset_cause

// [verification/watchdog_and_reset_cause_bench.sv]
// self-checking bench for the watchdog and reset-cause block
// assumes the package and design from rtl/, one 4 ns clock, design assertions inline
`timescale 1ns/100ps

module watchdog_and_reset_cause_bench;
  import watchdog_and_reset_cause_pkg::*;

  // ************************************************************
  // clock, reset and design hookup
  // ************************************************************
  localparam int GAP_SIM = 50;  // shortened missing clock limit

  logic           clock_i;      // system clock
  logic           rst_i;        // power-on reset
  logic           ce_i;         // clock enable
  sfr_req_t       sfr;          // register access
  reset_sources_t src;          // reset sources
  logic [7:0]     rdata_o;      // read data
  logic           sys_reset_o;  // internal reset
  logic           wd_active_o;  // watchdog running
  logic           mclk_run;     // monitored clock toggles when high
  logic           mclk = 1'b0;  // monitored clock level
  int             n_fail;       // mismatches
  int             n_tests;      // comparisons
  int             n;            // cycle count

  watchdog_and_reset_cause #(.GAP_CYCLES(GAP_SIM)) DUT (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .sfr_i       (sfr),
    .src_i       ({src.flash_error, src.comparator_n, src.supply_low, src.reset_pin_n, mclk}),
    .rdata_o     (rdata_o),
    .sys_reset_o (sys_reset_o),
    .wd_active_o (wd_active_o)
  );

  // free running clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // monitored clock, stops when the bench wants a stall
  always @(posedge clock_i) begin
    if (mclk_run) mclk <= #1 ~mclk;
  end

  // ************************************************************
  // tasks
  // ************************************************************
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one register write, taken at the second edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1 sfr.addr = a;
    sfr.wdata = d;
    sfr.wr = 1'b1;
    @(posedge clock_i);
    #1 sfr.wr = 1'b0;
  endtask

  // one register read, data valid after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock_i);
    #1 sfr.addr = a;
    sfr.rd = 1'b1;
    @(posedge clock_i);
    #1 sfr.rd = 1'b0;
    check(what, rdata_o, exp);
  endtask

  // cycles until the internal reset rises, capped
  task automatic count_to_reset(input int cap);
    n = 0;
    while (sys_reset_o !== 1'b1 && n < cap) begin
      @(posedge clock_i);
      #1 n++;
    end
  endtask

  // wait out an internal reset then read the cause
  task automatic cause(input logic [7:0] exp, input string what);
    count_to_reset(100);
    check({what, " entered"}, {7'h00, sys_reset_o}, 8'h01);
    n = 0;
    while (sys_reset_o !== 1'b0 && n < 100) begin
      @(posedge clock_i);
      #1 n++;
    end
    check({what, " left"}, {7'h00, sys_reset_o}, 8'h00);
    rd(RESET_CAUSE_ADDR, exp, what);
    rd(WATCHDOG_CONTROL_ADDR, WATCHDOG_CONTROL_RST, "control after reset");
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ************************************************************
  // watchdog against hangs
  // ************************************************************
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    n_fail = 0;
    n_tests = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    mclk_run = 1'b1;
    sfr = '0;
    src = '{flash_error: 1'b0, comparator_n: 1'b1, supply_low: 1'b0,
            reset_pin_n: 1'b1, monitored_clk: 1'b0};
    repeat (6) @(posedge clock_i);
    #1 rst_i = 1'b0;
    // power-on state
    cause(8'h02, "power on cause");
    check("active after reset", {7'h00, wd_active_o}, 8'h01);
    rd(8'h10, 8'h00, "unmapped read");
    // interval field and its gate bit
    wr(WATCHDOG_CONTROL_ADDR, 8'h00);
    rd(WATCHDOG_CONTROL_ADDR, 8'h10, "interval zero");
    wr(WATCHDOG_CONTROL_ADDR, 8'h83);
    rd(WATCHDOG_CONTROL_ADDR, 8'h10, "gated interval");
    // restart part way, then overflow 64 enabled cycles after the last restart
    wr(WATCHDOG_CONTROL_ADDR, KEY_RESTART);
    repeat (40) @(posedge clock_i);
    wr(WATCHDOG_CONTROL_ADDR, KEY_RESTART);
    // clock enable low freezes the count for 20 cycles
    ce_i = 1'b0;
    repeat (20) @(posedge clock_i);
    #1 ce_i = 1'b1;
    count_to_reset(100);
    check("timeout cycles", n[7:0], 8'h40);
    cause(8'h08, "watchdog cause");
    // disable keywords too far apart are ignored
    wr(WATCHDOG_CONTROL_ADDR, 8'h00);
    wr(WATCHDOG_CONTROL_ADDR, KEY_DISABLE_1);
    repeat (6) @(posedge clock_i);
    wr(WATCHDOG_CONTROL_ADDR, KEY_DISABLE_2);
    check("late disable", {7'h00, wd_active_o}, 8'h01);
    // another write between the keywords abandons the disable
    wr(WATCHDOG_CONTROL_ADDR, KEY_DISABLE_1);
    wr(WATCHDOG_CONTROL_ADDR, 8'h00);
    wr(WATCHDOG_CONTROL_ADDR, KEY_DISABLE_2);
    check("interrupted disable", {7'h00, wd_active_o}, 8'h01);
    // close keywords disable, no overflow afterwards
    wr(WATCHDOG_CONTROL_ADDR, KEY_RESTART);
    wr(WATCHDOG_CONTROL_ADDR, KEY_DISABLE_1);
    wr(WATCHDOG_CONTROL_ADDR, KEY_DISABLE_2);
    check("disabled", {7'h00, wd_active_o}, 8'h00);
    rd(WATCHDOG_CONTROL_ADDR, 8'h00, "status after disable");
    count_to_reset(300);
    check("no overflow when off", {7'h00, sys_reset_o}, 8'h00);
    // lockout neither restarts nor allows a disable
    wr(WATCHDOG_CONTROL_ADDR, KEY_RESTART);
    repeat (30) @(posedge clock_i);
    wr(WATCHDOG_CONTROL_ADDR, KEY_LOCK);
    wr(WATCHDOG_CONTROL_ADDR, KEY_DISABLE_1);
    wr(WATCHDOG_CONTROL_ADDR, KEY_DISABLE_2);
    check("locked active", {7'h00, wd_active_o}, 8'h01);
    count_to_reset(100);
    check("lock keeps count", n[7:0], 8'h1c);
    cause(8'h08, "watchdog cause again");
    // software reset, then flag bits ignore writes
    wr(RESET_CAUSE_ADDR, 8'h10);
    check("software reset at once", {7'h00, sys_reset_o}, 8'h01);
    cause(8'h10, "software cause");
    wr(RESET_CAUSE_ADDR, 8'h49);
    rd(RESET_CAUSE_ADDR, 8'h10, "read-only flags");
    // comparator source
    wr(RESET_CAUSE_ADDR, 8'h20);
    src.comparator_n = 1'b0;
    cause(8'h20, "comparator cause");
    src.comparator_n = 1'b1;
    // missing clock source
    wr(RESET_CAUSE_ADDR, 8'h04);
    mclk_run = 1'b0;
    cause(8'h04, "missing clock cause");
    mclk_run = 1'b1;
    // supply monitor source
    wr(RESET_CAUSE_ADDR, 8'h02);
    src.supply_low = 1'b1;
    cause(8'h02, "supply cause");
    src.supply_low = 1'b0;
    // pin source, reset held while the pin is low
    src.reset_pin_n = 1'b0;
    repeat (20) @(posedge clock_i);
    #1 check("pin holds reset", {7'h00, sys_reset_o}, 8'h01);
    src.reset_pin_n = 1'b1;
    cause(8'h01, "pin cause");
    // flash error source
    src.flash_error = 1'b1;
    @(posedge clock_i);
    #1 src.flash_error = 1'b0;
    cause(8'h40, "flash cause");
    end_sim();
  end

endmodule // watchdog_and_reset_cause_bench
